// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, rom_data = 1'b0, user_rst = 1'b0, lock = 1'b0;
  logic chan_done = 1'b0, chan_req, tx_rst, rx_rst, ana_rst, pll_rst;
  logic rd = 1'b0, wr = 1'b0, wr_all = 1'b0, op_done = 1'b0, busy, err;
  logic [2:0] mode_sel = 3'h0;
  logic [tpr_pkg::ROM_AW-1:0] rom_addr;
  logic [tpr_pkg::SCAN_LEN-1:0] rom_img = 16'h0, pll_cfg;
  logic [tpr_pkg::CHAN_N*tpr_pkg::SCAN_LEN-1:0] chan_cfg;
  int fails = 0, total_checks = 0, cycles = 0, lock_t = 0, rx_hi_t = 0;
  tpr_link_if link();
  always #5 clk = ~clk;
  tpr_ctrl_end u_tpr_ctrl_end (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .LINK(link), .ROM_ADDR_O(rom_addr),
    .ROM_DATA_I(rom_data), .USER_PLL_RESET_I(user_rst),
    .RX_FREQLOCKED_I(lock), .CHAN_RECONFIG_DONE_I(chan_done),
    .CHAN_RECONFIG_REQ_O(chan_req), .TX_DIGITAL_RESET_O(tx_rst),
    .RX_DIGITAL_RESET_O(rx_rst), .RX_ANALOG_RESET_O(ana_rst));
  tpr_pll_end u_tpr_pll_end (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .LINK(link), .PLL_CFG_O(pll_cfg), .CHAN_CFG_O(chan_cfg),
    .PLL_RESET_O(pll_rst), .RD_I(rd), .WR_I(wr), .WR_ALL_I(wr_all),
    .MODE_SEL_I(mode_sel), .OP_DONE_I(op_done), .BUSY_O(busy), .ERROR_O(err));
  tpr_link_sva u_chk (.CLOCK_I(clk), .RST_I(rst), .scanclk(link.scanclk),
    .scanclkena(link.scanclkena), .scandata(link.scandata),
    .configupdate(link.configupdate), .areset(link.areset),
    .reconfig_done(link.reconfig_done), .scandataout(link.scandataout));
  // ROM answers a cycle after the address; channel logic acks promptly
  always @(posedge clk)
  begin
    rom_data <= rom_img[tpr_pkg::SCAN_LEN-1-int'(rom_addr)];
    chan_done <= chan_req;
    cycles <= cycles + 1;
    if (rx_rst === 1'b1)
      rx_hi_t <= cycles;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task summarize();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // One full reload from ROM, with or without the divider sequence
  task run_cfg(input logic [15:0] img, input logic div);
    logic [31:0] q;
    logic e;
    logic [15:0] old;
    int n;
    old = pll_cfg;
    rom_img = img;
    n = 0;
    apb(1'b1, tpr_pkg::CTRL_OFF, {30'h0, div, 1'b1}, q, e);
    #1;
    if (div)
      chk({tx_rst, rx_rst, ana_rst}, 3'h7, "channel resets not held");
    do
    begin
      apb(1'b0, tpr_pkg::STATUS_OFF, 32'h0, q, e);
      if (div && !lock && tx_rst === 1'b0)
      begin
        chk({rx_rst, ana_rst}, 2'h2, "release order");
        lock <= 1'b1;
        lock_t = cycles;
      end
      n++;
    end
    while (q[0] !== 1'b0 && n < 400);
    chk(q[2:0], {lock, 2'b10}, "status after reload");
    chk(pll_cfg, img, "pll config");
    chk(chan_cfg, {tpr_pkg::CHAN_N{img}}, "channel copies");
    if (div)
      chk(rx_hi_t - lock_t >= tpr_pkg::LOCK_WAIT_CYC, 1'b1, "lock wait");
    apb(1'b0, tpr_pkg::RDBACK_OFF, 32'h0, q, e);
    chk(q[15:0], old, "readback of previous config");
    apb(1'b1, tpr_pkg::STATUS_OFF, 32'h2, q, e);
    apb(1'b0, tpr_pkg::STATUS_OFF, 32'h0, q, e);
    chk(q[1], 1'b0, "done not cleared");
  endtask
  // One request to the checker; d is the cycle of completion, -1 for none
  task op(input logic r, w, a, input logic [2:0] m, input int d, e, lo, hi);
    int busy_n;
    int err_n;
    busy_n = 0;
    err_n = 0;
    @(posedge clk);
    rd <= r;
    wr <= w;
    wr_all <= a;
    mode_sel <= m;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    wr_all <= 1'b0;
    for (int i = 0; i < 100; i++)
    begin
      #1;
      busy_n += (busy === 1'b1);
      err_n += (err === 1'b1);
      @(posedge clk);
      op_done <= (i == d);
    end
    chk(err_n, e, "error cycles");
    chk(busy_n >= lo && busy_n <= hi, 1'b1, "busy cycles");
  endtask
  initial
  begin
    logic [31:0] q;
    logic e;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({busy, err, link.scanclk, pll_rst}, 4'h0, "idle after reset");
    @(posedge clk);
    user_rst <= 1'b1;
    repeat (6) @(posedge clk);
    chk({link.areset, pll_rst}, 2'h3, "user pll reset");
    user_rst <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    chk(e, 1'b1, "unmapped address accepted");
    run_cfg(16'ha5c3, 1'b0);
    run_cfg(16'h3c5a, 1'b1);
    lock <= 1'b0;
    op(1'b1, 1'b0, 1'b0, 3'h0, -1, 2, 1, 1);
    op(1'b1, 1'b0, 1'b0, tpr_pkg::MODE_CHANNEL, -1, 2, 1, 1);
    op(1'b0, 1'b0, 1'b1, 3'h0, -1, 2, 1, 1);
    op(1'b0, 1'b1, 1'b0, 3'h2, 5, 0, 5, 9);
    op(1'b0, 1'b1, 1'b0, 3'h0, -1, 2, 64, 70);
    summarize();
  end
endmodule

// *** tpr_ctrl_end.sv ***
`timescale 1ns/1ps
module tpr_ctrl_end (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Link to the PLL
  tpr_link_if.ctrl LINK,
  // Configuration ROM
  output logic [tpr_pkg::ROM_AW-1:0] ROM_ADDR_O,
  input wire logic ROM_DATA_I,
  // Channel reset and reconfiguration
  input wire logic USER_PLL_RESET_I,
  input wire logic RX_FREQLOCKED_I,
  input wire logic CHAN_RECONFIG_DONE_I,
  output logic CHAN_RECONFIG_REQ_O,
  output logic TX_DIGITAL_RESET_O,
  output logic RX_DIGITAL_RESET_O,
  output logic RX_ANALOG_RESET_O
);
  // ****************************************
  // Synchronisers and scan clock divider
  // ****************************************
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] sclk_div_ff;
  logic sclk_ff;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
    end
    else if (CE_I)
    begin
      s1_ff <= {LINK.reconfig_done, LINK.scandataout, RX_FREQLOCKED_I};
      s2_ff <= s1_ff;
    end
  end

  wire done_s = s2_ff[2];
  wire dout_s = s2_ff[1];
  wire lock_s = s2_ff[0];
  wire div_wrap = sclk_div_ff == 3'(tpr_pkg::SCAN_HALF_CYC - 1);
  wire sclk_fall = div_wrap & sclk_ff;
  wire sclk_rise = div_wrap & ~sclk_ff;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      sclk_div_ff <= 3'h0;
      sclk_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      sclk_div_ff <= div_wrap ? 3'h0 : sclk_div_ff + 3'h1;
      if (div_wrap)
        sclk_ff <= ~sclk_ff;
    end
  end

  // ****************************************
  // APB registers
  // ****************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_SHIFT = 8'h02, ST_UPD = 8'h04, ST_WDONE = 8'h08,
    ST_PRST = 8'h10, ST_CHREQ = 8'h20, ST_LOCK = 8'h40, ST_FIN = 8'h80
  } tpr_ctl_state_t;

  tpr_ctl_state_t state_ff;
  logic divchg_ff;
  logic done_ff;
  logic [tpr_pkg::SCAN_LEN-1:0] rdback_ff;
  logic [31:0] prdata_ff;

  wire wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
  wire rd_set = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  wire sel_ctrl = PADDR_I == tpr_pkg::CTRL_OFF;
  wire sel_stat = PADDR_I == tpr_pkg::STATUS_OFF;
  wire sel_rdbk = PADDR_I == tpr_pkg::RDBACK_OFF;
  wire mapped = sel_ctrl | sel_stat | sel_rdbk;
  wire busy = state_ff != ST_IDLE;
  // Software must already have checked each channel's mode [R3]
  wire start = wr_acc & sel_ctrl & PWDATA_I[tpr_pkg::CTRL_START_BIT] & ~busy;
  wire [31:0] stat_word = {29'h0, lock_s, done_ff, busy};
  wire [31:0] rd_word;

  assign rd_word = sel_ctrl ? {30'h0, divchg_ff, 1'b0} :
                   sel_stat ? stat_word :
                   sel_rdbk ? {16'h0, rdback_ff} : 32'h0;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      divchg_ff <= tpr_pkg::CTRL_DIVCHG_RST;
      prdata_ff <= 32'h0;
      rdback_ff <= '0;
    end
    else if (CE_I)
    begin
      if (rd_set)
        prdata_ff <= rd_word;
      if (wr_acc && sel_ctrl && !busy)
        divchg_ff <= PWDATA_I[tpr_pkg::CTRL_DIVCHG_BIT];
      if (sclk_rise && LINK.scanclkena)
        rdback_ff <= {rdback_ff[tpr_pkg::SCAN_LEN-2:0], dout_s}; // [R11]
    end
  end

  assign PRDATA_O = prdata_ff;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  // ****************************************
  // Reconfiguration sequencer
  // ****************************************
  logic [4:0] bit_cnt_ff;
  logic [tpr_pkg::ROM_AW-1:0] rom_addr_ff;
  logic [9:0] cnt_ff;
  logic ena_ff;
  logic data_ff;
  logic upd_ff;
  logic arst_ff;
  logic chreq_ff;
  logic txd_ff;
  logic rxd_ff;
  logic rxa_ff;

  wire last_bit = bit_cnt_ff == 5'(tpr_pkg::SCAN_LEN);
  wire ar_end = cnt_ff == 10'(tpr_pkg::AR_CYC - 1);
  wire lock_end = cnt_ff == 10'(tpr_pkg::LOCK_WAIT_CYC - 1);
  // Done clears on status write; a completion in that cycle wins
  wire done_clr = wr_acc & sel_stat & PWDATA_I[tpr_pkg::ST_DONE_BIT];

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h0;
      rom_addr_ff <= '0;
      cnt_ff <= 10'h0;
      ena_ff <= 1'b0;
      data_ff <= 1'b0;
      upd_ff <= 1'b0;
      arst_ff <= 1'b0;
      chreq_ff <= 1'b0;
      txd_ff <= 1'b0;
      rxd_ff <= 1'b0;
      rxa_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      if (state_ff == ST_FIN)
        done_ff <= 1'b1;
      else if (done_clr)
        done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
          if (start)
          begin
            bit_cnt_ff <= 5'h0;
            rom_addr_ff <= '0;
            state_ff <= ST_SHIFT;
            // The divider bit lands in the same write as start
            if (PWDATA_I[tpr_pkg::CTRL_DIVCHG_BIT])
            begin
              txd_ff <= 1'b1; // [R12]
              rxd_ff <= 1'b1;
              rxa_ff <= 1'b1;
            end
          end
        ST_SHIFT:
          if (sclk_fall)
          begin
            if (last_bit)
            begin
              ena_ff <= 1'b0;
              upd_ff <= 1'b1; // [R9]
              state_ff <= ST_UPD;
            end
            else
            begin
              data_ff <= ROM_DATA_I; // [R4] [R7]
              ena_ff <= 1'b1; // [R8]
              bit_cnt_ff <= bit_cnt_ff + 5'h1;
              rom_addr_ff <= rom_addr_ff +
                             {{(tpr_pkg::ROM_AW-1){1'b0}}, 1'b1};
            end
          end
        // Done can come back before the update period ends
        ST_UPD:
          if (done_s)
          begin
            upd_ff <= 1'b0;
            arst_ff <= 1'b1; // [R6]
            cnt_ff <= 10'h0;
            state_ff <= ST_PRST;
          end
          else if (sclk_fall)
          begin
            upd_ff <= 1'b0;
            state_ff <= ST_WDONE;
          end
        ST_WDONE:
          if (done_s)
          begin
            arst_ff <= 1'b1; // [R6]
            cnt_ff <= 10'h0;
            state_ff <= ST_PRST;
          end
        ST_PRST:
          if (ar_end)
          begin
            arst_ff <= 1'b0;
            chreq_ff <= divchg_ff; // [R12]
            state_ff <= divchg_ff ? ST_CHREQ : ST_FIN;
          end
          else
            cnt_ff <= cnt_ff + 10'h1;
        ST_CHREQ:
          if (CHAN_RECONFIG_DONE_I)
          begin
            chreq_ff <= 1'b0;
            txd_ff <= 1'b0; // [R12]
            rxa_ff <= 1'b0;
            cnt_ff <= 10'h0;
            state_ff <= ST_LOCK;
          end
        ST_LOCK:
          if (!lock_s)
            cnt_ff <= 10'h0;
          else if (lock_end)
          begin
            rxd_ff <= 1'b0; // [R13]
            state_ff <= ST_FIN;
          end
          else
            cnt_ff <= cnt_ff + 10'h1;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  assign LINK.scanclk = sclk_ff;
  assign LINK.scanclkena = ena_ff;
  assign LINK.scandata = data_ff;
  assign LINK.configupdate = upd_ff;
  // User logic drives the PLL reset during power-up sequencing
  assign LINK.areset = USER_PLL_RESET_I | arst_ff; // [R5] [R6]
  assign ROM_ADDR_O = rom_addr_ff;
  assign CHAN_RECONFIG_REQ_O = chreq_ff;
  assign TX_DIGITAL_RESET_O = txd_ff;
  assign RX_DIGITAL_RESET_O = rxd_ff;
  assign RX_ANALOG_RESET_O = rxa_ff;
endmodule

// *** tpr_link_if.sv ***
`timescale 1ns/1ps
interface tpr_link_if;
  logic scanclk;
  logic scanclkena;
  logic scandata;
  logic configupdate;
  logic areset;
  logic reconfig_done;
  logic scandataout;
  modport ctrl (
    output scanclk, scanclkena, scandata, configupdate, areset,
    input reconfig_done, scandataout
  );
  modport pll (
    input scanclk, scanclkena, scandata, configupdate, areset,
    output reconfig_done, scandataout
  );
endinterface

// *** tpr_link_sva.sv ***
`timescale 1ns/1ps
module tpr_link_sva (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Link signals
  input wire logic scanclk,
  input wire logic scanclkena,
  input wire logic scandata,
  input wire logic configupdate,
  input wire logic areset,
  input wire logic reconfig_done,
  input wire logic scandataout
);
  // ****************************************
  // Link protocol checks
  // ****************************************
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  // Update follows the last enabled bit at the same scan fall
  sequence frame_end_s;
    $fell(scanclkena) ##0 $rose(configupdate);
  endsequence
  // Both ends resync the link, so allow a few cycles of slack
  sequence done_rise_s;
    ##[4:16] $rose(reconfig_done);
  endsequence
  ena_on_low_a: assert property ($changed(scanclkena) |-> !scanclk)
    else $error("scan enable moved while scan clock high");
  data_hold_a: assert property (scanclk |-> $stable(scandata))
    else $error("scan data moved while scan clock high");
  upd_last_a: assert property ($rose(configupdate) |-> frame_end_s)
    else $error("update not at end of frame");
  upd_width_a: assert property ($rose(configupdate) |-> configupdate[*8])
    else $error("update pulse too short");
  upd_excl_a: assert property (!(scanclkena && configupdate))
    else $error("update while shifting");
  done_after_upd_a: assert property (frame_end_s |-> done_rise_s)
    else $error("done did not follow update");
  done_hold_a: assert property (reconfig_done && !areset |=> reconfig_done)
    else $error("done dropped before reset");
  reset_after_done_a: assert property ($rose(reconfig_done) |-> ##[1:6] areset)
    else $error("no pll reset after done");
  reset_width_a: assert property ($rose(areset) |-> areset[*4])
    else $error("pll reset too short");
endmodule

// *** tpr_pkg.sv ***
// Summary of operation
// [R1] New PLL rate reaches every attached channel
// [R2] Only the PLL changes, channels keep settings
// [R3] Software checks channel modes support the rate
// [R4] Controller shifts the bit image from ROM
// [R5] User logic owns PLL reset at power-up
// [R6] PLL reset on first edge after done; the controller raises it on the third edge, after its two-flop sync
// [R7] Configuration bits enter serially on scan data
// [R8] Shift only on scan clock with enable
// [R9] Update only after the final bit
// [R10] Done output follows PLL shift completion
// [R11] Current configuration shifts out for readback
// [R12] Divider change: resets, PLL, channels, release
// [R13] Wait 4 us after lock, release rx logic
// [R14] Error output exists only when checks enabled
// [R15] Illegal request: drop busy, error two cycles
// [R16] Read illegal without analog readback outputs
// [R17] Write-all illegal without analog control inputs
// [R18] Read in channel mode is illegal
// [R19] Self-recovery abandons overlong operations
// [R20] Abandon: drop busy, error two cycles
// [R21] Out-of-range analog write raises no error
// [R22] Error low otherwise; busy from accept to end
package tpr_pkg;
  // ****************************************
  // Scan chain and link timing
  // ****************************************
  localparam int SCAN_LEN = 16;
  localparam int ROM_AW = 4;
  localparam int CHAN_N = 4;
  localparam int SCAN_HALF_CYC = 8;
  localparam int DONE_DELAY_CYC = 4;
  localparam int AR_CYC = 4;
  localparam int CLK_MHZ = 100;
  localparam int LOCK_WAIT_US = 4;
  localparam int LOCK_WAIT_CYC = LOCK_WAIT_US * CLK_MHZ;
  // ****************************************
  // Error checker
  // ****************************************
  localparam int ERR_CYC = 2;
  localparam int OP_TIMEOUT_CYC = 64;
  localparam logic [2:0] MODE_CHANNEL = 3'h1;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] RDBACK_OFF = 12'h008;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DIVCHG_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam logic CTRL_DIVCHG_RST = 1'h0;
endpackage

// *** tpr_pll_end.sv ***
`timescale 1ns/1ps
module tpr_pll_end #(
  parameter bit ILLEGAL_CHECK_EN = 1'b1,
  parameter bit SELF_RECOVERY_EN = 1'b1,
  parameter bit ANALOG_OUT_EN = 1'b0,
  parameter bit ANALOG_IN_EN = 1'b0
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Link to the reconfiguration controller
  tpr_link_if.pll LINK,
  // PLL state
  output logic [tpr_pkg::SCAN_LEN-1:0] PLL_CFG_O,
  output logic [tpr_pkg::CHAN_N*tpr_pkg::SCAN_LEN-1:0] CHAN_CFG_O,
  output logic PLL_RESET_O,
  // Reconfiguration requests
  input wire logic RD_I,
  input wire logic WR_I,
  input wire logic WR_ALL_I,
  input wire logic [2:0] MODE_SEL_I,
  input wire logic OP_DONE_I,
  output logic BUSY_O,
  output logic ERROR_O
);
  // ****************************************
  // Link input synchronisers
  // ****************************************
  localparam int NS = 5;
  localparam int I_CLK = 4;
  localparam int I_ENA = 3;
  localparam int I_DAT = 2;
  localparam int I_UPD = 1;
  localparam int I_RST = 0;

  logic [NS-1:0] raw_in;
  logic [NS-1:0] s1_ff;
  logic [NS-1:0] s2_ff;
  logic [NS-1:0] s3_ff;

  assign raw_in = {LINK.scanclk, LINK.scanclkena, LINK.scandata,
                   LINK.configupdate, LINK.areset};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_sync
      always_ff @(posedge CLOCK_I)
      begin
        if (RST_I)
        begin
          s1_ff[gi] <= 1'b0;
          s2_ff[gi] <= 1'b0;
          s3_ff[gi] <= 1'b0;
        end
        else if (CE_I)
        begin
          s1_ff[gi] <= raw_in[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
        end
      end
    end
  endgenerate

  // All link lines see the same delay, so data stays aligned to clock
  wire sclk_rise = s2_ff[I_CLK] & ~s3_ff[I_CLK];
  wire shift_en = sclk_rise & s2_ff[I_ENA]; // [R8]
  wire upd_rise = s2_ff[I_UPD] & ~s3_ff[I_UPD];
  wire rst_rise = s2_ff[I_RST] & ~s3_ff[I_RST];

  // ****************************************
  // Scan chain and active configuration
  // ****************************************
  logic [tpr_pkg::SCAN_LEN-1:0] chain_ff;
  logic [tpr_pkg::SCAN_LEN-1:0] cfg_ff;
  logic dout_ff;
  logic done_ff;
  logic dly_run_ff;
  logic [2:0] dly_ff;
  logic pll_rst_ff;

  wire dly_end = dly_run_ff &&
                 (dly_ff == 3'(tpr_pkg::DONE_DELAY_CYC - 1));

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      chain_ff <= '0;
      dout_ff <= 1'b0;
    end
    else if (CE_I && shift_en)
    begin
      chain_ff <= {chain_ff[tpr_pkg::SCAN_LEN-2:0], s2_ff[I_DAT]}; // [R7]
      dout_ff <= chain_ff[tpr_pkg::SCAN_LEN-2]; // [R11]
    end
    else if (CE_I)
    begin
      dout_ff <= chain_ff[tpr_pkg::SCAN_LEN-1]; // [R11]
    end
  end

  // Only the PLL word changes; channel blocks are not touched here
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      cfg_ff <= '0;
    end
    else if (CE_I && upd_rise)
    begin
      cfg_ff <= chain_ff; // [R2]
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      dly_run_ff <= 1'b0;
      dly_ff <= 3'h0;
    end
    else if (CE_I)
    begin
      if (upd_rise)
      begin
        dly_run_ff <= 1'b1;
        dly_ff <= 3'h0;
      end
      else if (dly_end)
      begin
        dly_run_ff <= 1'b0;
      end
      else if (dly_run_ff)
      begin
        dly_ff <= dly_ff + 3'h1;
      end
    end
  end

  // Set wins over the clear by the following PLL reset
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      done_ff <= 1'b0;
      pll_rst_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      pll_rst_ff <= s2_ff[I_RST];
      if (dly_end)
      begin
        done_ff <= 1'b1; // [R10]
      end
      else if (rst_rise)
      begin
        done_ff <= 1'b0;
      end
    end
  end

  assign LINK.reconfig_done = done_ff; // [R10]
  assign LINK.scandataout = dout_ff;
  assign PLL_CFG_O = cfg_ff;
  assign PLL_RESET_O = pll_rst_ff;

  generate
    for (gi = 0; gi < tpr_pkg::CHAN_N; gi++)
    begin : g_chan
      assign CHAN_CFG_O[gi*tpr_pkg::SCAN_LEN +: tpr_pkg::SCAN_LEN] =
        cfg_ff; // [R1]
    end
  endgenerate

  // ****************************************
  // Request checker
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CHECK = 4'h2,
    ST_RUN = 4'h4,
    ST_ERR = 4'h8
  } tpr_chk_state_t;

  tpr_chk_state_t state_ff;
  tpr_chk_state_t nxt_state;
  logic rd_ff;
  logic wall_ff;
  logic [2:0] mode_ff;
  logic [6:0] tmo_ff;
  logic err_cnt_ff;

  function automatic logic illegal_req(input logic rd, input logic wall,
                                       input logic [2:0] mode);
    logic bad;
    bad = 1'b0;
    if (rd && !ANALOG_OUT_EN)
      bad = 1'b1; // [R16]
    if (wall && !ANALOG_IN_EN)
      bad = 1'b1; // [R17]
    if (rd && mode == tpr_pkg::MODE_CHANNEL)
      bad = 1'b1; // [R18]
    return bad;
  endfunction

  // Plain writes never qualify, whatever value they carry
  wire req = RD_I | WR_I | WR_ALL_I; // [R21]
  wire bad_req = ILLEGAL_CHECK_EN &&
                 illegal_req(rd_ff, wall_ff, mode_ff); // [R15]
  wire tmo_hit = SELF_RECOVERY_EN &&
                 (tmo_ff == 7'(tpr_pkg::OP_TIMEOUT_CYC - 1)); // [R19]

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (req)
          nxt_state = ST_CHECK;
      ST_CHECK:
        if (bad_req)
          nxt_state = ST_ERR; // [R15]
        else
          nxt_state = ST_RUN;
      ST_RUN:
        if (OP_DONE_I)
          nxt_state = ST_IDLE;
        else if (tmo_hit)
          nxt_state = ST_ERR; // [R20]
      ST_ERR:
        if (err_cnt_ff)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      state_ff <= ST_IDLE;
      rd_ff <= 1'b0;
      wall_ff <= 1'b0;
      mode_ff <= 3'h0;
    end
    else if (CE_I)
    begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE && req)
      begin
        rd_ff <= RD_I;
        wall_ff <= WR_ALL_I;
        mode_ff <= MODE_SEL_I;
      end
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      tmo_ff <= 7'h0;
      err_cnt_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      tmo_ff <= (state_ff == ST_RUN) ? tmo_ff + 7'h1 : 7'h0;
      err_cnt_ff <= (state_ff == ST_ERR) ? ~err_cnt_ff : 1'b0;
    end
  end

  // ERR lasts exactly ERR_CYC cycles (err_cnt_ff counts two)
  assign BUSY_O = (state_ff == ST_CHECK) || (state_ff == ST_RUN); // [R22]
  assign ERROR_O = (ILLEGAL_CHECK_EN || SELF_RECOVERY_EN) &&
                   (state_ff == ST_ERR); // [R14] [R22]
endmodule
